/* File: core/pm_regs_pkg.sv */
`default_nettype none

package pm_regs_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register indices; the byte address on the bus is four times the index
	localparam logic [9:0] PM_CAP_IDX = 10'h0DE;
	localparam logic [9:0] PM_CSR_IDX = 10'h0E0;
	localparam logic [9:0] BR_EXT_IDX = 10'h0E2;
	localparam logic [9:0] PM_DATA_IDX = 10'h0E3;

	////////////////////////////////////////////////////////////////////////
	// Capability word, held in bits 15:0 of its bus word
	localparam int PM_REV_LSB = 0;
	localparam int PM_REV_MSB = 2;
	localparam logic [2:0] PM_REV_VAL = 3'h1;
	localparam int CAP_WAKE_CLK_BIT = 3;
	localparam int CAP_AUX_BIT = 4;
	localparam int CAP_DSI_BIT = 5;
	localparam int CAP_D1_BIT = 9;
	localparam int CAP_D2_BIT = 10;
	localparam int CAP_WAKE_LSB = 11;
	localparam int CAP_WAKE_MSB = 15;
	localparam logic [12:0] CAP_UPPER_VAL = 13'h0000;

	////////////////////////////////////////////////////////////////////////
	// Power control word, held in bits 15:0 of its bus word
	localparam int PS_LSB = 0;
	localparam int PS_MSB = 1;
	localparam int CSR_WAKE_EN_BIT = 8;
	localparam int CSR_DSEL_LSB = 9;
	localparam int CSR_DSEL_MSB = 12;
	localparam int CSR_DSCALE_LSB = 13;
	localparam int CSR_DSCALE_MSB = 14;
	localparam int CSR_WAKE_STS_BIT = 15;
	localparam logic [13:0] CSR_UPPER_VAL = 14'h0000;

	typedef enum logic [1:0] {
		PS_D0 = 2'h0,
		PS_D1 = 2'h1,
		PS_D2 = 2'h2,
		PS_D3 = 2'h3
	} pstate_t;

	localparam pstate_t PS_RESET = PS_D0;

	////////////////////////////////////////////////////////////////////////
	// Support extensions byte, held in bits 7:0 of its bus word
	localparam int EXT_CLK_STOP_BIT = 6;
	localparam int EXT_CTRL_EN_BIT = 7;
	localparam logic [5:0] EXT_RSVD_VAL = 6'h00;

	// Power data byte
	localparam logic [7:0] PM_DATA_VAL = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CHIP_RST_CYCLES = 16;

endpackage

`default_nettype wire

/* File: core/strap_sync.sv */
`default_nettype none

module strap_sync
	import pm_regs_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic pin,
	output logic level
);

	// First stage feeds only the second stage
	logic meta_r;
	logic level_r;

	always_ff @(posedge clk) begin
		if (reset) begin
			meta_r <= 1'b0;
			level_r <= 1'b0;
		end else begin
			meta_r <= pin;
			level_r <= meta_r;
		end
	end

	assign level = level_r;

endmodule

`default_nettype wire

/* File: core/reset_stretch.sv */
`default_nettype none

module reset_stretch
	import pm_regs_pkg::*;
#(
	parameter int CYCLES = CHIP_RST_CYCLES
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic start,
	output logic active
);

	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LOAD = CW'(CYCLES);

	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic active_r;

	// A restart while running reloads the full length
	assign cnt_nxt = start ? LOAD : (cnt_r != '0) ? cnt_r - CW'(1) : cnt_r;

	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_r <= '0;
			active_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			active_r <= (cnt_nxt != '0);
		end
	end

	assign active = active_r;

endmodule

`default_nettype wire

/* File: core/bridge_power_mgmt_regs.sv */
`default_nettype none

module bridge_power_mgmt_regs
	import pm_regs_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int RST_CYCLES = CHIP_RST_CYCLES
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic bus_pwr_clk_ctrl_strap,
	output logic chip_reset,
	output logic sec_clk_stop,
	output logic sec_bus_rst_n
);

	////////////////////////////////////////////////////////////////////////
	// Decode helpers

	function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [9:0] idx);
		reg_hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(idx));
	endfunction

	function automatic logic ps_legal(input logic [1:0] v);
		ps_legal = (v == PS_D0) || (v == PS_D3);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Strap and chip reset

	logic strap_s;
	logic chip_rst_start;

	strap_sync u_strap (
		.clk(clk),
		.reset(reset),
		.pin(bus_pwr_clk_ctrl_strap),
		.level(strap_s)
	);

	reset_stretch #(
		.CYCLES(RST_CYCLES)
	) u_chip_rst (
		.clk(clk),
		.reset(reset),
		.start(chip_rst_start),
		.active(chip_reset)
	);

	////////////////////////////////////////////////////////////////////////
	// Bus handshake
	// One wait state keeps read data and error both from flip-flops

	logic pready_r;
	logic pslverr_r;
	logic [31:0] prdata_r;
	wire access = psel & penable;
	wire done = access & pready_r;
	wire wr_en = done & pwrite;

	wire hit_cap = reg_hit(paddr, PM_CAP_IDX);
	wire hit_csr = reg_hit(paddr, PM_CSR_IDX);
	wire hit_ext = reg_hit(paddr, BR_EXT_IDX);
	wire hit_data = reg_hit(paddr, PM_DATA_IDX);
	wire hit_any = hit_cap | hit_csr | hit_ext | hit_data;

	////////////////////////////////////////////////////////////////////////
	// Power state

	pstate_t ps_r;
	pstate_t ps_nxt;
	logic sec_clk_stop_r;
	logic sec_bus_rst_n_r;

	wire [1:0] ps_wdata = pwdata[PS_MSB:PS_LSB];
	wire ps_wr = wr_en & hit_csr & pstrb[0];
	// Unimplemented codes are dropped; the access still completes
	wire ps_wr_ok = ps_wr & ps_legal(ps_wdata);

	assign ps_nxt = ps_wr_ok ? pstate_t'(ps_wdata) : ps_r;
	assign chip_rst_start = ps_wr_ok && (ps_r == PS_D3) && (ps_wdata == PS_D0);

	always_ff @(posedge clk) begin
		if (reset) begin
			ps_r <= PS_RESET;
		end else begin
			ps_r <= ps_nxt;
		end
	end

	// Secondary clocks stop only when the strap enables the mechanism
	always_ff @(posedge clk) begin
		if (reset) begin
			sec_clk_stop_r <= 1'b0;
		end else begin
			sec_clk_stop_r <= strap_s & (ps_r == PS_D3);
		end
	end

	// The chip reset from D3 exit leaves this output alone
	always_ff @(posedge clk) begin
		if (reset) begin
			sec_bus_rst_n_r <= 1'b0;
		end else begin
			sec_bus_rst_n_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read words

	wire [15:0] cap_word = {CAP_UPPER_VAL, PM_REV_VAL};
	wire [15:0] csr_word = {CSR_UPPER_VAL, ps_r};
	// Clock stop flag follows the strap; zero when disabled
	wire clock_stop_in_d3hot_flag = strap_s;
	wire [7:0] ext_word = {strap_s, clock_stop_in_d3hot_flag, EXT_RSVD_VAL};
	wire [7:0] data_word = PM_DATA_VAL;

	wire [31:0] rd_word = hit_cap ? {16'h0000, cap_word} :
		hit_csr ? {16'h0000, csr_word} :
		hit_ext ? {24'h000000, ext_word} :
		hit_data ? {24'h000000, data_word} : 32'h00000000;

	always_ff @(posedge clk) begin
		if (reset) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h00000000;
		end else begin
			pready_r <= access & ~pready_r;
			pslverr_r <= access & ~pready_r & ~hit_any;
			prdata_r <= (access & ~pready_r & ~pwrite) ? rd_word : 32'h00000000;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign sec_clk_stop = sec_clk_stop_r;
	assign sec_bus_rst_n = sec_bus_rst_n_r;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk);
	endclocking

	default disable iff (reset);

	wire rd_done = done & ~pwrite;
	logic was_reset_r;

	always_ff @(posedge clk) begin
		was_reset_r <= reset;
	end

	// Counts chip reset cycles since the last start, so a restart is measured from its own start
	localparam int LW = $clog2(RST_CYCLES + 1);
	logic [LW-1:0] rst_len_r;

	always_ff @(posedge clk) begin
		if (reset) begin
			rst_len_r <= '0;
		end else if (chip_rst_start) begin
			rst_len_r <= '0;
		end else if (chip_reset) begin
			rst_len_r <= rst_len_r + LW'(1);
		end
	end

	sequence s_wr_d3;
		wr_en && hit_csr && pstrb[0] && (pwdata[1:0] == PS_D3);
	endsequence

	sequence s_wr_d0;
		wr_en && hit_csr && pstrb[0] && (pwdata[1:0] == PS_D0);
	endsequence

	sequence s_rst_pulse;
		chip_reset [*3];
	endsequence

	sequence s_setup;
		psel && !penable;
	endsequence

	sequence s_wait;
		access && !pready;
	endsequence

	sequence s_done;
		access && pready;
	endsequence

	cap_rev_a: assert property (
		rd_done && hit_cap |-> prdata[PM_REV_MSB:PM_REV_LSB] == 3'h1
	) else $error("Revision field not 001");

	cap_wake_a: assert property (
		rd_done && hit_cap |-> !prdata[CAP_WAKE_CLK_BIT] && prdata[CAP_WAKE_MSB:CAP_WAKE_LSB] == 5'h00
	) else $error("Wake support bits not zero");

	cap_aux_a: assert property (
		rd_done && hit_cap |-> !prdata[CAP_AUX_BIT]
	) else $error("Aux power bit set");

	cap_dsi_a: assert property (
		rd_done && hit_cap |-> !prdata[CAP_DSI_BIT] && prdata[8:6] == 3'h0
	) else $error("Init or reserved bits set");

	cap_d1_a: assert property (
		rd_done && hit_cap |-> !prdata[CAP_D1_BIT]
	) else $error("D1 support bit set");

	cap_d2_a: assert property (
		rd_done && hit_cap |-> !prdata[CAP_D2_BIT] && prdata[31:16] == 16'h0000
	) else $error("D2 support bit set");

	ps_reset_a: assert property (
		was_reset_r |-> ps_r == PS_D0
	) else $error("Power state not D0 after reset");

	ps_readback_a: assert property (
		s_wr_d3 ##[1:3] (psel && !penable && !pwrite && hit_csr) ##1 access [*2]
		|-> prdata[1:0] == PS_D3
	) else $error("D3 write not read back");

	ps_ignore_a: assert property (
		ps_wr && !ps_legal(ps_wdata) |=> $stable(ps_r) && !chip_reset
	) else $error("Illegal state code changed field");

	ps_complete_a: assert property (
		s_wait ##0 hit_csr |=> (s_done ##0 !pslverr) or !access
	) else $error("Access did not complete");

	d3_exit_a: assert property (
		(ps_r == PS_D3) and s_wr_d0 |=> s_rst_pulse ##0 sec_bus_rst_n
	) else $error("No chip reset on D3 exit");

	no_sec_rst_a: assert property (
		chip_reset |-> sec_bus_rst_n
	) else $error("Secondary reset asserted by chip reset");

	csr_ro_a: assert property (
		rd_done && hit_csr |-> prdata[31:2] == 30'h00000000
	) else $error("Control word read-only bits not zero");

	clk_stop_a: assert property (
		(strap_s && ps_r == PS_D3) [*2] |-> sec_clk_stop
	) else $error("Secondary clocks not stopped in D3");

	clk_run_a: assert property (
		$past(ps_r) == PS_D0 |-> !sec_clk_stop
	) else $error("Secondary clocks stopped outside D3");

	stop_flag_a: assert property (
		rd_done && hit_ext |-> prdata[EXT_CLK_STOP_BIT] == prdata[EXT_CTRL_EN_BIT]
	) else $error("Clock stop flag disagrees with strap bit");

	strap_a: assert property (
		$stable(bus_pwr_clk_ctrl_strap) [*3] ##1 rd_done && hit_ext
		|-> prdata[EXT_CTRL_EN_BIT] == $past(bus_pwr_clk_ctrl_strap, 3)
	) else $error("Enable bit does not mirror strap");

	data_a: assert property (
		rd_done && hit_data |-> prdata == 32'h00000000
	) else $error("Data byte not zero");

	unmapped_a: assert property (
		rd_done && !hit_any |-> pslverr && prdata == 32'h00000000
	) else $error("Unmapped read not refused");

	first_wait_a: assert property (
		s_setup ##1 access |-> !pready
	) else $error("Access answered without a wait state");

	ready_pulse_a: assert property (
		pready |=> !pready
	) else $error("Ready held longer than one cycle");

	ready_idle_a: assert property (
		!access |=> !pready
	) else $error("Ready without an access");

	err_ready_a: assert property (
		pslverr |-> pready
	) else $error("Error without ready");

	rdata_idle_a: assert property (
		!pready |-> prdata == 32'h00000000
	) else $error("Read data not zero outside completion");

	wr_rdata_a: assert property (
		done && pwrite |-> prdata == 32'h00000000
	) else $error("Read data driven on a write");

	ext_rsvd_a: assert property (
		rd_done && hit_ext |-> prdata[5:0] == 6'h00 && prdata[31:8] == 24'h000000
	) else $error("Extension reserved bits not zero");

	rst_len_a: assert property (
		$fell(chip_reset) |-> rst_len_r == LW'(RST_CYCLES)
	) else $error("Chip reset length wrong");

	rst_cause_a: assert property (
		$rose(chip_reset) |-> $past(ps_r) == PS_D3 && ps_r == PS_D0
	) else $error("Chip reset without D3 exit");

	ps_hold_a: assert property (
		!ps_wr |=> $stable(ps_r)
	) else $error("Power state changed without a write");

	ps_legal_a: assert property (
		ps_r == PS_D0 || ps_r == PS_D3
	) else $error("Power state holds an unimplemented code");

	ps_write_a: assert property (
		ps_wr && ps_legal(ps_wdata) |=> ps_r == $past(ps_wdata)
	) else $error("Legal state write not taken");

	stop_cause_a: assert property (
		sec_clk_stop |-> $past(ps_r) == PS_D3 && $past(strap_s)
	) else $error("Secondary clocks stopped without cause");

	sec_rst_high_a: assert property (
		!was_reset_r |-> sec_bus_rst_n
	) else $error("Secondary reset low after reset");

endmodule

`default_nettype wire

/* File: tb/apb_host.sv */
`default_nettype none

module apb_host (
	input wire logic clk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		pstrb = 4'h0;
	end

	////////////////////////////////////////////////////////////////////////
	// Waits as long as the slave needs; only the bench watchdog ends a hang
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] rd, output logic err);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released address and write data show the inverse, so stale values are never read as valid
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule

`default_nettype wire

/* File: tb/bridge_power_mgmt_regs_tb_top.sv */
`default_nettype none

module bridge_power_mgmt_regs_tb_top
	import pm_regs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int RST = 4;
	localparam logic [11:0] A_CAP = {PM_CAP_IDX, 2'b00};
	localparam logic [11:0] A_CSR = {PM_CSR_IDX, 2'b00};
	localparam logic [11:0] A_EXT = {BR_EXT_IDX, 2'b00};
	localparam logic [11:0] A_DATA = {PM_DATA_IDX, 2'b00};

	logic clk = 1'b0;
	logic reset = 1'b1;
	logic strap = 1'b0;
	logic psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	logic chip_reset, sec_clk_stop, sec_bus_rst_n;
	logic mon = 1'b0;
	int failures = 0;
	int n_checks = 0;
	int cr_cnt = 0;
	int low_cnt = 0;

	always #12.5 clk = ~clk;

	bridge_power_mgmt_regs #(.ADDR_W(12), .RST_CYCLES(RST)) i_dut (.clk(clk), .reset(reset),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.bus_pwr_clk_ctrl_strap(strap), .chip_reset(chip_reset), .sec_clk_stop(sec_clk_stop),
		.sec_bus_rst_n(sec_bus_rst_n));

	apb_host i_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	always @(posedge clk) begin
		if (chip_reset === 1'b1)
			cr_cnt <= cr_cnt + 1;
		if (mon && sec_bus_rst_n !== 1'b1)
			low_cnt <= low_cnt + 1;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		chk_word({31'h0, got}, {31'h0, exp});
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] rd;
		logic err;
		i_host.xfer(1'b1, a, d, s, rd, err);
		chk_bit(err, 1'b0);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] rd;
		logic err;
		i_host.xfer(1'b0, a, 32'h0000_0000, 4'h0, rd, err);
		chk_word(rd, exp);
	endtask

	// Only D0 and D3 are kept, and only when the low byte is strobed
	function automatic logic [1:0] next_ps(input logic [1:0] cur, input logic [31:0] d, input logic [3:0] s);
		if (s[0] && (d[1:0] == 2'h0 || d[1:0] == 2'h3))
			return d[1:0];
		return cur;
	endfunction

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		end_sim();
	end

	initial begin
		logic [31:0] d, rd;
		logic [3:0] s;
		logic [1:0] ps;
		logic err;
		int cr0;
		void'($urandom(11));
		ps = 2'h0;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		repeat (2) @(posedge clk);
		mon <= 1'b1;
		chk_bit(sec_bus_rst_n, 1'b1);
		rd_chk(A_CAP, 32'h0000_0001);
		rd_chk(A_CSR, 32'h0000_0000);
		rd_chk(A_DATA, 32'h0000_0000);
		wr(A_CAP, 32'hFFFF_FFFF, 4'hF);
		wr(A_DATA, 32'hFFFF_FFFF, 4'hF);
		wr(A_CSR, 32'hFFFF_FFFC, 4'hF);
		rd_chk(A_CAP, 32'h0000_0001);
		rd_chk(A_DATA, 32'h0000_0000);
		rd_chk(A_CSR, 32'h0000_0000);
		for (int i = 0; i < 2; i++) begin
			strap <= i[0];
			wr(A_EXT, 32'hFFFF_FFFF, 4'hF);
			rd_chk(A_EXT, {24'h0, {2{i[0]}}, 6'h00});
			wr(A_CSR, 32'h0000_0003, 4'hF);
			repeat (3) @(posedge clk);
			chk_bit(sec_clk_stop, i[0]);
			wr(A_CSR, 32'h0000_0001, 4'hF);
			rd_chk(A_CSR, 32'h0000_0003);
			wr(A_CSR, 32'h0000_0002, 4'hF);
			wr(A_CSR, 32'h0000_0000, 4'hE);
			rd_chk(A_CSR, 32'h0000_0003);
			cr0 = cr_cnt;
			wr(A_CSR, 32'h0000_0000, 4'hF);
			repeat (RST + 3) @(posedge clk);
			chk_word(32'(cr_cnt - cr0), 32'(RST));
			chk_bit(sec_clk_stop, 1'b0);
			rd_chk(A_CSR, 32'h0000_0000);
		end
		chk_word(32'(low_cnt), 32'h0000_0000);
		// Unmapped word just below the capability word
		i_host.xfer(1'b0, A_CAP - 12'h004, 32'h0000_0000, 4'h0, rd, err);
		chk_bit(err, 1'b1);
		chk_word(rd, 32'h0000_0000);
		repeat (60) begin
			d = $urandom;
			s = 4'($urandom);
			wr(A_CSR, d, s);
			ps = next_ps(ps, d, s);
			rd_chk(A_CSR, {30'h0, ps});
			chk_bit(sec_clk_stop, ps == 2'h3);
		end
		end_sim();
	end
endmodule

`default_nettype wire
